// ===== hdl/hcd_pkg.sv
// Constants shared by the host capability and channel decode register bank.
package hcd_pkg;

  // Configuration space offsets, byte addresses of aligned dwords.
  localparam logic [11:0] CFG_SCRATCH_OFS = 12'h0DC;
  localparam logic [11:0] CFG_CAP_LO_OFS = 12'h0E0;
  localparam logic [11:0] CFG_CAP_HI_OFS = 12'h0E4;

  // Memory window offsets.
  localparam logic [15:0] MMIO_CHDEC_OFS = 16'h0111;
  localparam logic [15:0] MMIO_CHDEC_DW = 16'h0110;
  localparam int unsigned MMIO_CHDEC_LANE = 1;
  localparam logic [15:0] MMIO_FREQ_OFS = 16'h0C00;

  // Reset values.
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [7:0] CHDEC_RST = 8'h00;
  localparam logic [2:0] FREQ_SEL_RST = 3'h0;

  // Capability word field positions.
  localparam int unsigned CAP_DEVID_LSB = 55;
  localparam int unsigned CAP_REVID_LSB = 51;
  localparam int unsigned CAP_GFX_ABSENT_BIT = 46;
  localparam int unsigned CAP_OVERLAP_OFF_BIT = 43;
  localparam int unsigned CAP_XOR_OFF_BIT = 42;
  localparam int unsigned CAP_DUAL_OFF_BIT = 40;
  localparam int unsigned CAP_FREQ_LSB = 31;
  localparam int unsigned CAP_VER_LSB = 24;
  localparam int unsigned CAP_LEN_LSB = 16;
  localparam int unsigned CAP_NEXT_LSB = 8;
  localparam int unsigned CAP_TYPE_LSB = 0;

  // Capability word constants.
  localparam logic [3:0] CAP_STRUCT_VERSION = 4'h1;
  localparam logic [7:0] CAP_STRUCT_LENGTH = 8'h08;
  localparam logic [7:0] CAP_NEXT_POINTER = 8'h00;
  localparam logic [7:0] CAP_TYPE_VENDOR = 8'h09;

  // Frequency capability codes.
  localparam logic [2:0] FREQ_CAP_ALL = 3'h0;
  localparam logic [2:0] FREQ_CAP_800 = 3'h5;
  localparam logic [2:0] FREQ_CAP_667 = 3'h6;

  // Channel decode field positions.
  localparam int unsigned CHDEC_DIMM_BIT = 7;
  localparam int unsigned CHDEC_MODE_LSB = 5;
  localparam int unsigned CHDEC_CH0_BIT = 2;
  localparam logic [7:0] CHDEC_WR_MASK = 8'hE4;
  localparam logic [1:0] MODE_SWAP_BOTH = 2'h0;
  localparam logic [1:0] MODE_XOR_BOTH = 2'h1;
  localparam logic [1:0] MODE_SWAP_BANK = 2'h2;
  localparam logic [1:0] MODE_XOR_BANK = 2'h3;

  // Frequency select field position in its dword.
  localparam int unsigned FREQ_SEL_LSB = 4;

  // Configuration device number of the graphics device.
  localparam logic [4:0] GFX_DEV_NUM = 5'h02;

  // Fuse settle time after reset release.
  localparam int unsigned FUSE_SETTLE_NS = 20;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FUSE_SETTLE_CYC = (FUSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : hcd_pkg

// ===== hdl/hcd_fuse_capture.sv
// Synchroniser and one-time capture of the capability fuse levels.
`timescale 1ns/10ps
module hcd_fuse_capture #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] fuse_in,
  output logic [WIDTH-1:0] fuse_value,
  output logic fuse_valid
);

  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] sync3_reg;
  logic [WIDTH-1:0] agree;
  logic [3:0] settle_reg;

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          sync3_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= fuse_in[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
        end
      end
      assign agree[i] = (sync2_reg[i] == sync3_reg[i]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fuses are caught once after reset, so capability bits never move while
  // software runs even if a fuse line glitches later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_reg <= 4'h0;
    end else if (settle_reg != 4'(hcd_pkg::FUSE_SETTLE_CYC)) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fuse_value <= '0;
      fuse_valid <= 1'b0;
    end else if (!fuse_valid && settle_reg == 4'(hcd_pkg::FUSE_SETTLE_CYC) && (&agree)) begin
      fuse_value <= sync3_reg;
      fuse_valid <= 1'b1;
    end
  end

endmodule : hcd_fuse_capture

// ===== hdl/hcd_regs.sv
// Scratch, capability and channel decode registers of the host bridge.
`timescale 1ns/10ps
module hcd_regs #(
  // Arbitrary identity values, not those of any real part.
  parameter logic [2:0] CAP_DEVICE_IDENTIFIER = 3'h5,
  parameter logic [3:0] COMPAT_REVISION_IDENTIFIER = 4'hA,
  // Frequency select codes, ordered by rate; a select at or below the limit passes.
  parameter logic [2:0] FREQ_CODE_800 = 3'h3,
  parameter logic [2:0] FREQ_CODE_667 = 3'h2
) (
  input wire logic clk,
  input wire logic nrst,
  // Configuration space access.
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [4:0] cfg_dev,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ready,
  output logic [31:0] cfg_rdata,
  output logic gfx_cfg_claim,
  output logic gfx_cfg_forward,
  // Memory window access.
  input wire logic mmio_valid,
  input wire logic mmio_write,
  input wire logic [15:0] mmio_addr,
  input wire logic [3:0] mmio_be,
  input wire logic [31:0] mmio_wdata,
  output logic mmio_ready,
  output logic [31:0] mmio_rdata,
  output logic freq_write_ignored,
  // Lock of the lockable decode fields.
  input wire logic decode_lock,
  // Capability fuses from outside the clock domain.
  input wire logic graphics_absent_fuse,
  input wire logic overlap_sched_off_fuse,
  input wire logic addr_xor_off_fuse,
  input wire logic dual_display_off_fuse,
  input wire logic [2:0] mem_freq_capability_fuse,
  // Graphics device control.
  input wire logic [1:0] device_enable_gfx,
  output logic [1:0] gfx_function_enable,
  output logic gfx_clock_enable,
  output logic cap_fuses_valid,
  // Memory controller controls.
  output logic sched_overlap_allowed,
  output logic [2:0] mem_freq_select,
  output logic chan0_enhanced_enable,
  output logic enhanced_dimm_select,
  output logic bank_swap_enable,
  output logic bank_xor_enable,
  output logic rank_swap_enable,
  output logic rank_xor_enable
);

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0] fuse_value;
  logic graphics_absent_flag;
  logic overlap_sched_off;
  logic addr_xor_off;
  logic dual_display_off;
  logic [2:0] mem_freq_capability;
  logic [63:0] capability_word;
  logic [31:0] scratch_storage_reg;
  logic [7:0] channel_decode_misc_reg;
  logic [7:0] chdec_view;
  logic [1:0] enhanced_mode_choice;
  logic [2:0] freq_sel_reg;
  logic [2:0] freq_wr_value;
  logic freq_wr_hit;
  logic freq_allowed;
  logic chdec_wr_hit;
  logic [7:0] chdec_wr_byte;
  logic [7:0] chdec_next;
  logic scratch_hit;

  hcd_fuse_capture #(
    .WIDTH(7)
  ) u_fuse (
    .clk(clk),
    .nrst(nrst),
    .fuse_in({mem_freq_capability_fuse, dual_display_off_fuse, addr_xor_off_fuse,
              overlap_sched_off_fuse, graphics_absent_fuse}),
    .fuse_value(fuse_value),
    .fuse_valid(cap_fuses_valid)
  );

  assign graphics_absent_flag = fuse_value[0];
  assign overlap_sched_off = fuse_value[1];
  assign addr_xor_off = fuse_value[2];
  assign dual_display_off = fuse_value[3];
  assign mem_freq_capability = fuse_value[6:4];

  ////////////////////////////////////////////////////////////////////////////
  // Capability word; every bit not named here is reserved and reads zero.
  always_comb begin
    capability_word = 64'h0000_0000_0000_0000;
    capability_word[hcd_pkg::CAP_DEVID_LSB +: 3] = CAP_DEVICE_IDENTIFIER;
    capability_word[hcd_pkg::CAP_REVID_LSB +: 4] = COMPAT_REVISION_IDENTIFIER;
    capability_word[hcd_pkg::CAP_GFX_ABSENT_BIT] = graphics_absent_flag;
    capability_word[hcd_pkg::CAP_OVERLAP_OFF_BIT] = overlap_sched_off;
    capability_word[hcd_pkg::CAP_XOR_OFF_BIT] = addr_xor_off;
    capability_word[hcd_pkg::CAP_DUAL_OFF_BIT] = dual_display_off;
    capability_word[hcd_pkg::CAP_FREQ_LSB +: 3] = mem_freq_capability;
    capability_word[hcd_pkg::CAP_VER_LSB +: 4] = hcd_pkg::CAP_STRUCT_VERSION;
    capability_word[hcd_pkg::CAP_LEN_LSB +: 8] = hcd_pkg::CAP_STRUCT_LENGTH;
    capability_word[hcd_pkg::CAP_NEXT_LSB +: 8] = hcd_pkg::CAP_NEXT_POINTER;
    capability_word[hcd_pkg::CAP_TYPE_LSB +: 8] = hcd_pkg::CAP_TYPE_VENDOR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space: only device 0 registers live here.
  assign scratch_hit = cfg_valid && cfg_write && (cfg_dev == 5'h00) &&
                       (cfg_addr == hcd_pkg::CFG_SCRATCH_OFS);

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_scratch
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          scratch_storage_reg[8*b +: 8] <= hcd_pkg::SCRATCH_RST[8*b +: 8];
        end else if (scratch_hit && cfg_be[b]) begin
          scratch_storage_reg[8*b +: 8] <= cfg_wdata[8*b +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ready <= 1'b0;
    end else begin
      cfg_ready <= cfg_valid && !cfg_ready;
    end
  end

  // Read data is registered; writes to the capability word fall through. 
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_valid && !cfg_ready) begin
      if (cfg_write || cfg_dev != 5'h00) begin
        cfg_rdata <= 32'h0000_0000;
      end else if (cfg_addr == hcd_pkg::CFG_SCRATCH_OFS) begin
        cfg_rdata <= scratch_storage_reg;
      end else if (cfg_addr == hcd_pkg::CFG_CAP_LO_OFS) begin
        cfg_rdata <= capability_word[31:0];
      end else if (cfg_addr == hcd_pkg::CFG_CAP_HI_OFS) begin
        cfg_rdata <= capability_word[63:32];
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // Cycles for the graphics device are either kept or sent downstream.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gfx_cfg_claim <= 1'b0;
      gfx_cfg_forward <= 1'b0;
    end else begin
      gfx_cfg_claim <= cfg_valid && !cfg_ready && (cfg_dev == hcd_pkg::GFX_DEV_NUM) &&
                       !graphics_absent_flag;
      gfx_cfg_forward <= cfg_valid && !cfg_ready && (cfg_dev == hcd_pkg::GFX_DEV_NUM) &&
                         graphics_absent_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Graphics clocks and functions. Function 1 also vanishes without dual display.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gfx_clock_enable <= 1'b0;
      gfx_function_enable <= 2'h0;
    end else begin
      gfx_clock_enable <= cap_fuses_valid && !graphics_absent_flag;
      if (!cap_fuses_valid || graphics_absent_flag) begin
        gfx_function_enable <= 2'h0;
      end else begin
        gfx_function_enable[0] <= device_enable_gfx[0];
        gfx_function_enable[1] <= device_enable_gfx[1] && !dual_display_off;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sched_overlap_allowed <= 1'b0;
    end else begin
      sched_overlap_allowed <= cap_fuses_valid && !overlap_sched_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory window: channel decode byte and the frequency select field.
  assign chdec_wr_hit = mmio_valid && mmio_write && !mmio_ready &&
                        (mmio_addr == hcd_pkg::MMIO_CHDEC_DW) &&
                        mmio_be[hcd_pkg::MMIO_CHDEC_LANE] && !decode_lock;
  assign chdec_wr_byte = mmio_wdata[8*hcd_pkg::MMIO_CHDEC_LANE +: 8];

  always_comb begin
    chdec_next = (channel_decode_misc_reg & ~hcd_pkg::CHDEC_WR_MASK) |
                 (chdec_wr_byte & hcd_pkg::CHDEC_WR_MASK);
    if (addr_xor_off) begin
      chdec_next[hcd_pkg::CHDEC_MODE_LSB +: 2] = hcd_pkg::MODE_SWAP_BANK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_decode_misc_reg <= hcd_pkg::CHDEC_RST;
    end else if (chdec_wr_hit) begin
      channel_decode_misc_reg <= chdec_next;
    end
  end

  // The forced mode applies even before any write reaches the register.
  assign enhanced_mode_choice = addr_xor_off ? hcd_pkg::MODE_SWAP_BANK :
                                channel_decode_misc_reg[hcd_pkg::CHDEC_MODE_LSB +: 2];

  always_comb begin
    chdec_view = channel_decode_misc_reg;
    chdec_view[hcd_pkg::CHDEC_MODE_LSB +: 2] = enhanced_mode_choice;
  end

  // Frequency select writes outside the capability are dropped whole.
  always_comb begin
    case (mem_freq_capability)
      hcd_pkg::FREQ_CAP_ALL: freq_allowed = 1'b1;
      hcd_pkg::FREQ_CAP_800: freq_allowed = (freq_wr_value <= FREQ_CODE_800);
      hcd_pkg::FREQ_CAP_667: freq_allowed = (freq_wr_value <= FREQ_CODE_667);
      default: freq_allowed = 1'b0;
    endcase
  end

  assign freq_wr_hit = mmio_valid && mmio_write && !mmio_ready &&
                       (mmio_addr == hcd_pkg::MMIO_FREQ_OFS) && mmio_be[0];
  assign freq_wr_value = mmio_wdata[hcd_pkg::FREQ_SEL_LSB +: 3];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freq_sel_reg <= hcd_pkg::FREQ_SEL_RST;
      freq_write_ignored <= 1'b0;
    end else begin
      freq_write_ignored <= freq_wr_hit && !freq_allowed;
      if (freq_wr_hit && freq_allowed) begin
        freq_sel_reg <= freq_wr_value;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mmio_ready <= 1'b0;
    end else begin
      mmio_ready <= mmio_valid && !mmio_ready;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mmio_rdata <= 32'h0000_0000;
    end else if (mmio_valid && !mmio_ready) begin
      if (mmio_write) begin
        mmio_rdata <= 32'h0000_0000;
      end else if (mmio_addr == hcd_pkg::MMIO_CHDEC_DW) begin
        mmio_rdata <= {16'h0000, chdec_view, 8'h00};
      end else if (mmio_addr == hcd_pkg::MMIO_FREQ_OFS) begin
        mmio_rdata <= {25'h0, freq_sel_reg, 4'h0};
      end else begin
        mmio_rdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls to the address mapper. Software is trusted to pair
  // channels and populate ranks correctly; hardware does not check it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan0_enhanced_enable <= 1'b0;
      enhanced_dimm_select <= 1'b0;
      bank_swap_enable <= 1'b0;
      bank_xor_enable <= 1'b0;
      rank_swap_enable <= 1'b0;
      rank_xor_enable <= 1'b0;
      mem_freq_select <= hcd_pkg::FREQ_SEL_RST;
    end else begin
      mem_freq_select <= freq_sel_reg;
      chan0_enhanced_enable <= channel_decode_misc_reg[hcd_pkg::CHDEC_CH0_BIT];
      enhanced_dimm_select <= channel_decode_misc_reg[hcd_pkg::CHDEC_DIMM_BIT];
      case (enhanced_mode_choice)
        hcd_pkg::MODE_SWAP_BOTH: begin
          bank_swap_enable <= 1'b1;
          bank_xor_enable <= 1'b0;
          rank_swap_enable <= 1'b1;
          rank_xor_enable <= 1'b0;
        end
        hcd_pkg::MODE_XOR_BOTH: begin
          bank_swap_enable <= 1'b0;
          bank_xor_enable <= 1'b1;
          rank_swap_enable <= 1'b0;
          rank_xor_enable <= 1'b1;
        end
        hcd_pkg::MODE_SWAP_BANK: begin
          bank_swap_enable <= 1'b1;
          bank_xor_enable <= 1'b0;
          rank_swap_enable <= 1'b0;
          rank_xor_enable <= 1'b0;
        end
        default: begin
          bank_swap_enable <= 1'b0;
          bank_xor_enable <= 1'b1;
          rank_swap_enable <= 1'b0;
          rank_xor_enable <= 1'b0;
        end
      endcase
    end
  end

endmodule : hcd_regs

// ===== verification/hcd_regs_chk.sv
// Concurrent checks on the ports of the capability and channel decode register bank.
`timescale 1ns/10ps
module hcd_regs_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic mmio_valid,
  input wire logic mmio_ready,
  input wire logic gfx_cfg_claim,
  input wire logic gfx_cfg_forward,
  input wire logic gfx_clock_enable,
  input wire logic [1:0] gfx_function_enable,
  input wire logic cap_fuses_valid,
  input wire logic overlap_sched_off_fuse,
  input wire logic addr_xor_off_fuse,
  input wire logic dual_display_off_fuse,
  input wire logic sched_overlap_allowed,
  input wire logic freq_write_ignored,
  input wire logic [2:0] mem_freq_select,
  input wire logic bank_swap_enable,
  input wire logic bank_xor_enable,
  input wire logic rank_swap_enable,
  input wire logic rank_xor_enable
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Fuse-derived outputs may lag the valid flag by one register stage.
  sequence seq_settled;
    cap_fuses_valid [*2];
  endsequence
  sequence seq_cfg_answer;
    cfg_ready ##1 !cfg_ready;
  endsequence
  sequence seq_mmio_answer;
    mmio_ready ##1 !mmio_ready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chk_cfg_answer_once: assert property (cfg_valid && !cfg_ready |=> seq_cfg_answer)
    else $error("config answer is not one single cycle");
  chk_mmio_answer_once: assert property (mmio_valid && !mmio_ready |=> seq_mmio_answer)
    else $error("window answer is not one single cycle");
  chk_gfx_claim_present: assert property (gfx_cfg_claim |-> cfg_ready && gfx_clock_enable && !gfx_cfg_forward)
    else $error("graphics claim without present graphics");
  chk_gfx_forward_hidden: assert property (gfx_cfg_forward |-> cfg_ready && !gfx_clock_enable && gfx_function_enable == 2'h0)
    else $error("graphics forward while graphics visible");
  chk_overlap_sched_cap: assert property (seq_settled |-> sched_overlap_allowed == !overlap_sched_off_fuse)
    else $error("overlap permission differs from fuse");
  chk_freq_drop_hold: assert property (freq_write_ignored |-> mmio_ready ##1 $stable(mem_freq_select))
    else $error("dropped frequency write changed the select");
  chk_mode_one_kind: assert property ((bank_xor_enable |-> !bank_swap_enable) and (rank_swap_enable |-> bank_swap_enable) and (rank_xor_enable |-> bank_xor_enable))
    else $error("mode decode outputs inconsistent");
  chk_xor_hardwired: assert property (seq_settled ##0 addr_xor_off_fuse |-> !bank_xor_enable && !rank_xor_enable && !rank_swap_enable)
    else $error("xor or rank mode active while xor disabled");
  chk_dual_display_off: assert property (seq_settled ##0 dual_display_off_fuse |-> !gfx_function_enable[1])
    else $error("second graphics function visible");
endmodule : hcd_regs_chk

// ===== verification/tb_hcd_regs.sv
// Self-checking bench of the capability and channel decode register bank.
`timescale 1ns/10ps
module tb_hcd_regs;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic v = 1'b0;
  logic sel = 1'b0;
  logic w = 1'b0;
  logic decode_lock = 1'b0;
  logic [4:0] dev = 5'h00;
  logic [15:0] a = 16'h0000;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [6:0] fz = 7'h00;
  logic [1:0] device_enable_reg = 2'h0;
  logic [31:0] rdv, cfg_rdata, mmio_rdata;
  logic claim, fwd, ign, rdy, cfg_ready, mmio_ready, gfx_cfg_claim, gfx_cfg_forward;
  logic freq_write_ignored, gfx_clock_enable, cap_fuses_valid, sched_overlap_allowed;
  logic chan0_enhanced_enable, enhanced_dimm_select, bank_swap_enable, bank_xor_enable;
  logic rank_swap_enable, rank_xor_enable;
  logic [1:0] gfx_function_enable;
  logic [2:0] mem_freq_select;
  logic [5:0] dec_out;
  logic [3:0] mode_map [4] = '{4'hA, 4'h5, 4'h8, 4'h4};
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  assign rdy = sel ? mmio_ready : cfg_ready;
  assign dec_out = {enhanced_dimm_select, chan0_enhanced_enable, bank_swap_enable,
    bank_xor_enable, rank_swap_enable, rank_xor_enable};

  // One shared master drives both ports; sel steers valid so only one is ever requested.
  hcd_regs uut (
    .clk(clk), .nrst(nrst), .cfg_valid(v & ~sel), .cfg_write(w), .cfg_dev(dev),
    .cfg_addr(a[11:0]), .cfg_be(be), .cfg_wdata(wd), .cfg_ready(cfg_ready),
    .cfg_rdata(cfg_rdata), .gfx_cfg_claim(gfx_cfg_claim), .gfx_cfg_forward(gfx_cfg_forward),
    .mmio_valid(v & sel), .mmio_write(w), .mmio_addr(a), .mmio_be(be), .mmio_wdata(wd),
    .mmio_ready(mmio_ready), .mmio_rdata(mmio_rdata), .freq_write_ignored(freq_write_ignored),
    .decode_lock(decode_lock), .graphics_absent_fuse(fz[6]), .overlap_sched_off_fuse(fz[5]),
    .addr_xor_off_fuse(fz[4]), .dual_display_off_fuse(fz[3]),
    .mem_freq_capability_fuse(fz[2:0]), .device_enable_gfx(device_enable_reg),
    .gfx_function_enable(gfx_function_enable), .gfx_clock_enable(gfx_clock_enable),
    .cap_fuses_valid(cap_fuses_valid), .sched_overlap_allowed(sched_overlap_allowed),
    .mem_freq_select(mem_freq_select), .chan0_enhanced_enable(chan0_enhanced_enable),
    .enhanced_dimm_select(enhanced_dimm_select), .bank_swap_enable(bank_swap_enable),
    .bank_xor_enable(bank_xor_enable), .rank_swap_enable(rank_swap_enable),
    .rank_xor_enable(rank_xor_enable)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The answer is taken at the rising edge where ready is sampled high, and the request
  // is released at that same edge, so a held valid never opens a second cycle.
  task automatic bus(input logic s, input logic wr, input logic [4:0] d, input logic [15:0] ad,
      input logic [3:0] b, input logic [31:0] wdv);
    int n;
    n = 0;
    @(posedge clk);
    sel <= s;
    w <= wr;
    dev <= d;
    a <= ad;
    be <= b;
    wd <= wdv;
    v <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 10);
    check(32'(n), 32'h2);
    rdv = s ? mmio_rdata : cfg_rdata;
    claim = gfx_cfg_claim;
    fwd = gfx_cfg_forward;
    ign = freq_write_ignored;
    v <= 1'b0;
  endtask : bus

  task automatic wr(input logic s, input logic [15:0] ad, input logic [3:0] b,
      input logic [31:0] d);
    bus(s, 1'b1, 5'h00, ad, b, d);
  endtask : wr

  task automatic rd(input logic s, input logic [15:0] ad);
    bus(s, 1'b0, 5'h00, ad, 4'hF, 32'h0);
  endtask : rd

  task automatic do_reset(input logic [6:0] f);
    int n;
    @(posedge clk);
    nrst <= 1'b0;
    fz <= f;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cap_fuses_valid !== 1'b1 && n < 40);
    check({31'h0, cap_fuses_valid}, 32'h1);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_scratch;
    rd(1'b0, 16'h00DC);
    check(rdv, 32'h0);
    wr(1'b0, 16'h00DC, 4'hF, 32'h1234_5678);
    wr(1'b0, 16'h00DC, 4'h5, 32'hAABB_CCDD);
    rd(1'b0, 16'h00DC);
    check(rdv, 32'h12BB_56DD);
    wr(1'b0, 16'h00E0, 4'hF, 32'hFFFF_FFFF);
    rd(1'b0, 16'h00E0);
    check(rdv, 32'h0108_0009);
    rd(1'b0, 16'h00F0);
    check(rdv, 32'h0);
  endtask : t_scratch

  task automatic t_fuses(input logic [6:0] f, input logic [1:0] dv, input logic [31:0] lo,
      input logic [31:0] hi);
    logic [2:0] g;
    do_reset(f);
    @(posedge clk);
    device_enable_reg <= dv;
    rd(1'b0, 16'h00E0);
    check(rdv, lo);
    rd(1'b0, 16'h00E4);
    check(rdv, hi);
    bus(1'b0, 1'b0, 5'h02, 16'h0000, 4'hF, 32'h0);
    check({30'h0, claim, fwd}, {30'h0, ~f[6], f[6]});
    g = f[6] ? 3'h0 : {1'b1, dv & {~f[3], 1'b1}};
    check({29'h0, gfx_clock_enable, gfx_function_enable}, {29'h0, g});
    check({31'h0, sched_overlap_allowed}, {31'h0, ~f[5]});
  endtask : t_fuses

  task automatic t_decode;
    logic [7:0] b;
    for (int m = 0; m < 4; m++) begin
      b = {1'b1, 2'(m), 5'h1F};
      wr(1'b1, 16'h0110, 4'h2, {16'h0, b, 8'h00});
      rd(1'b1, 16'h0110);
      check(rdv, {16'h0, b & 8'hE4, 8'h00});
      check({26'h0, dec_out}, {26'h0, 2'h3, mode_map[m]});
    end
    @(posedge clk);
    decode_lock <= 1'b1;
    wr(1'b1, 16'h0110, 4'h2, 32'h0);
    rd(1'b1, 16'h0110);
    check(rdv, 32'h0000_E400);
    @(posedge clk);
    decode_lock <= 1'b0;
  endtask : t_decode

  task automatic t_xor;
    wr(1'b1, 16'h0110, 4'h2, 32'h0000_FF00);
    rd(1'b1, 16'h0110);
    check(rdv, 32'h0000_C400);
    check({26'h0, dec_out}, 32'h38);
    wr(1'b1, 16'h0110, 4'h2, 32'h0);
    rd(1'b1, 16'h0110);
    check(rdv, 32'h0000_4000);
  endtask : t_xor

  task automatic t_freq(input logic [2:0] val, input logic ok, input logic [2:0] exp);
    wr(1'b1, 16'h0C00, 4'hF, {25'h0, val, 4'h0});
    check({31'h0, ign}, {31'h0, ~ok});
    rd(1'b1, 16'h0C00);
    check(rdv, {25'h0, exp, 4'h0});
    check({29'h0, mem_freq_select}, {29'h0, exp});
  endtask : t_freq

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_fuses(7'h00, 2'h3, 32'h0108_0009, 32'h02D0_0000);
    t_scratch();
    t_decode();
    t_freq(3'h7, 1'b1, 3'h7);
    t_fuses(7'h7D, 2'h3, 32'h8108_0009, 32'h02D0_4D02);
    t_xor();
    t_freq(3'h4, 1'b0, 3'h0);
    t_freq(3'h3, 1'b1, 3'h3);
    t_fuses(7'h0E, 2'h2, 32'h0108_0009, 32'h02D0_0103);
    t_freq(3'h3, 1'b0, 3'h0);
    t_freq(3'h2, 1'b1, 3'h2);
    // A reserved frequency capability code lets no select through at all.
    t_fuses(7'h01, 2'h1, 32'h8108_0009, 32'h02D0_0000);
    t_freq(3'h1, 1'b0, 3'h0);
    give_verdict();
  end
endmodule : tb_hcd_regs

bind hcd_regs hcd_regs_chk chk (
  .clk(clk), .nrst(nrst), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
  .mmio_valid(mmio_valid), .mmio_ready(mmio_ready), .gfx_cfg_claim(gfx_cfg_claim),
  .gfx_cfg_forward(gfx_cfg_forward), .gfx_clock_enable(gfx_clock_enable),
  .gfx_function_enable(gfx_function_enable), .cap_fuses_valid(cap_fuses_valid),
  .overlap_sched_off_fuse(overlap_sched_off_fuse), .addr_xor_off_fuse(addr_xor_off_fuse),
  .dual_display_off_fuse(dual_display_off_fuse), .sched_overlap_allowed(sched_overlap_allowed),
  .freq_write_ignored(freq_write_ignored), .mem_freq_select(mem_freq_select),
  .bank_swap_enable(bank_swap_enable), .bank_xor_enable(bank_xor_enable),
  .rank_swap_enable(rank_swap_enable), .rank_xor_enable(rank_xor_enable)
);
